// file: break_compare.sv
// Purpose: channel A and channel B break-condition compare with register port
// Assumes: bus cycle inputs come from logic on clk; one register access per strobe
// Notes: match outputs pulse one cycle after the matching bus cycle
// limitation: channel B compares the address only; its qualifiers live in a neighbour
// trade-off: one register stage on every output costs a cycle of break latency
//
// Functional notes
// RULE_01: a clear channel A mask bit keeps that address bit in the compare.
// RULE_02: a set channel A mask bit drops that address bit; any bit maskable.
// RULE_03: A bus select: 00 off, 01 L bus, 10 I bus, 11 L bus.
// RULE_04: A cycle type: 00 off, 01 fetch, 10 data, 11 either.
// RULE_05: A direction: 00 off, 01 read, 10 write, 11 either.
// RULE_06: A size: 00 any, 01 byte, 10 word, 11 longword.
// RULE_07: qualifier register bits 15 to 8 read zero; software writes zero.
// RULE_08: channel B holds a 32-bit address compared on its selected bus.
// RULE_09: a set channel B mask bit drops that address bit; clear keeps it.
// RULE_10: channel A holds a 32-bit address compared on its selected bus.
// RULE_11: A matches only when address and every enabled field agree in one cycle.
`timescale 1ns/1ps
module break_compare (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rd_data,
   input wire break_pkg::bus_cycle_t local_addr_bus,
   input wire break_pkg::bus_cycle_t internal_addr_bus,
   output logic match_a,
   output logic match_b,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic [31:0] a_addr;
      logic [31:0] a_mask;
      logic [7:0] a_qual;
      logic [31:0] b_addr;
      logic [31:0] b_mask;
      logic [1:0] b_sel;
      logic [1:0] evt_status;
      logic [1:0] evt_mask;
      logic match_a;
      logic match_b;
      logic irq;
      logic [31:0] rd_data;
   } state_t;

   state_t q_reg;
   state_t q_next;

   logic [1:0] a_sel;
   logic [1:0] a_type;
   logic [1:0] a_dir;
   logic [1:0] a_size;
   break_pkg::bus_cycle_t pick_a;
   break_pkg::bus_cycle_t pick_b;
   logic a_addr_hit;
   logic b_addr_hit;
   logic type_ok;
   logic dir_ok;
   logic size_ok;
   logic a_hit_now;
   logic b_hit_now;
   logic [1:0] evt_now;
   logic [1:0] evt_clr;

   assign a_sel = q_reg.a_qual[break_pkg::QUAL_BUS_SEL_POS +: 2];
   assign a_type = q_reg.a_qual[break_pkg::QUAL_TYPE_POS +: 2];
   assign a_dir = q_reg.a_qual[break_pkg::QUAL_DIR_POS +: 2];
   assign a_size = q_reg.a_qual[break_pkg::QUAL_SIZE_POS +: 2];

   ////////////////////////////////////////////////////////////////////////////////
   // bus selection and address compare

   bus_pick pick_a_inst (
      .sel(a_sel),
      .l_cycle(local_addr_bus),
      .i_cycle(internal_addr_bus),
      .picked(pick_a)
   );

   // channel B bus choice uses the same code set as channel A
   bus_pick pick_b_inst (
      .sel(q_reg.b_sel),
      .l_cycle(local_addr_bus),
      .i_cycle(internal_addr_bus),
      .picked(pick_b)
   );

   addr_match #(.WIDTH(32)) match_a_inst (
      .addr(pick_a.addr),
      .ref_addr(q_reg.a_addr),
      .mask(q_reg.a_mask),
      .hit(a_addr_hit)
   );

   addr_match #(.WIDTH(32)) match_b_inst (
      .addr(pick_b.addr),
      .ref_addr(q_reg.b_addr),
      .mask(q_reg.b_mask),
      .hit(b_addr_hit)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // channel A qualifiers

   always_comb begin
      unique case (a_type)
         break_pkg::TYPE_FETCH: type_ok = pick_a.fetch; // RULE_04
         break_pkg::TYPE_DATA: type_ok = !pick_a.fetch; // RULE_04
         break_pkg::TYPE_BOTH: type_ok = 1'b1; // RULE_04
         default: type_ok = 1'b0; // RULE_04
      endcase
      unique case (a_dir)
         break_pkg::DIR_READ: dir_ok = !pick_a.write; // RULE_05
         break_pkg::DIR_WRITE: dir_ok = pick_a.write; // RULE_05
         break_pkg::DIR_BOTH: dir_ok = 1'b1; // RULE_05
         default: dir_ok = 1'b0; // RULE_05
      endcase
      // size 00 leaves operand size out; other codes demand that exact size
      size_ok = (a_size == break_pkg::SIZE_ANY) || (a_size == pick_a.size); // RULE_06
   end

   // all terms are taken from the same bus cycle, so no partial match can latch
   assign a_hit_now = pick_a.valid && type_ok && dir_ok && size_ok && a_addr_hit; // RULE_11
   assign b_hit_now = pick_b.valid && b_addr_hit; // RULE_08

   ////////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      q_next = q_reg;
      evt_now = '0;
      evt_clr = '0;
      evt_now[break_pkg::EVT_A_POS] = a_hit_now;
      evt_now[break_pkg::EVT_B_POS] = b_hit_now;
      q_next.match_a = a_hit_now; // RULE_10
      q_next.match_b = b_hit_now; // RULE_08
      q_next.rd_data = '0;

      if (wr_en) begin
         case (addr)
            break_pkg::OFF_A_MATCH_ADDR: q_next.a_addr = wr_data; // RULE_10
            break_pkg::OFF_A_ADDR_MASK: q_next.a_mask = wr_data; // RULE_02
            // upper bits are not stored at all, so they cannot read back
            break_pkg::OFF_A_CYCLE_QUAL: q_next.a_qual = wr_data[7:0]; // RULE_07
            break_pkg::OFF_B_MATCH_ADDR: q_next.b_addr = wr_data; // RULE_08
            break_pkg::OFF_B_ADDR_MASK: q_next.b_mask = wr_data; // RULE_09
            break_pkg::OFF_B_BUS_SEL: q_next.b_sel = wr_data[1:0];
            break_pkg::OFF_EVT_STATUS: evt_clr = wr_data[1:0];
            break_pkg::OFF_EVT_MASK: q_next.evt_mask = wr_data[1:0];
            default: begin
            end
         endcase
      end

      if (rd_en) begin
         case (addr)
            break_pkg::OFF_A_MATCH_ADDR: q_next.rd_data = q_reg.a_addr;
            break_pkg::OFF_A_ADDR_MASK: q_next.rd_data = q_reg.a_mask;
            break_pkg::OFF_A_CYCLE_QUAL: q_next.rd_data = {24'h00_0000, q_reg.a_qual}; // RULE_07
            break_pkg::OFF_B_MATCH_ADDR: q_next.rd_data = q_reg.b_addr;
            break_pkg::OFF_B_ADDR_MASK: q_next.rd_data = q_reg.b_mask;
            break_pkg::OFF_B_BUS_SEL: q_next.rd_data = {30'h0000_0000, q_reg.b_sel};
            break_pkg::OFF_EVT_STATUS: q_next.rd_data = {30'h0000_0000, q_reg.evt_status};
            break_pkg::OFF_EVT_MASK: q_next.rd_data = {30'h0000_0000, q_reg.evt_mask};
            default: q_next.rd_data = '0;
         endcase
      end

      // a new event in the clearing cycle survives the clear
      q_next.evt_status = (q_reg.evt_status & ~evt_clr) | evt_now;
      q_next.irq = |(q_next.evt_status & q_next.evt_mask);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q_reg.a_addr <= break_pkg::RST_ADDR;
         q_reg.a_mask <= break_pkg::RST_MASK;
         q_reg.a_qual <= break_pkg::RST_QUAL;
         q_reg.b_addr <= break_pkg::RST_ADDR;
         q_reg.b_mask <= break_pkg::RST_MASK;
         q_reg.b_sel <= break_pkg::RST_SEL;
         q_reg.evt_status <= break_pkg::RST_EVT;
         q_reg.evt_mask <= break_pkg::RST_EVT;
         q_reg.match_a <= 1'b0;
         q_reg.match_b <= 1'b0;
         q_reg.irq <= 1'b0;
         q_reg.rd_data <= '0;
      end else begin
         q_reg <= q_next;
      end
   end

   assign rd_data = q_reg.rd_data;
   assign match_a = q_reg.match_a;
   assign match_b = q_reg.match_b;
   assign irq = q_reg.irq;

   ////////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   logic a_all_open;
   assign a_all_open = (a_sel != break_pkg::SEL_OFF) && (a_type == break_pkg::TYPE_BOTH)
      && (a_dir == break_pkg::DIR_BOTH) && (a_size == break_pkg::SIZE_ANY);

   a_unmasked_differs: assert property ( // RULE_01
      (((pick_a.addr ^ q_reg.a_addr) & ~q_reg.a_mask) != '0) |=> !match_a)
      else $error("channel A matched with an unmasked address bit differing");

   a_full_mask_hit: assert property ( // RULE_02
      (a_all_open && pick_a.valid && (q_reg.a_mask == 32'hFFFF_FFFF)) |=> match_a)
      else $error("channel A missed a cycle with all address bits masked");

   a_bus_sel_off: assert property ( // RULE_03
      (a_sel == break_pkg::SEL_OFF) |=> !match_a)
      else $error("channel A matched with bus select disabled");

   a_ibus_source: assert property ( // RULE_03
      (a_sel == break_pkg::SEL_I && !internal_addr_bus.valid) |=> !match_a)
      else $error("channel A matched without an I bus cycle");

   a_fetch_only: assert property ( // RULE_04
      ((a_type == break_pkg::TYPE_FETCH && !pick_a.fetch)
       || a_type == 2'h0) |=> !match_a)
      else $error("channel A matched a cycle of the wrong type");

   a_read_only: assert property ( // RULE_05
      ((a_dir == break_pkg::DIR_READ && pick_a.write)
       || a_dir == 2'h0) |=> !match_a)
      else $error("channel A matched a cycle of the wrong direction");

   a_size_differs: assert property ( // RULE_06
      (a_size != break_pkg::SIZE_ANY && a_size != pick_a.size) |=> !match_a)
      else $error("channel A matched a cycle of the wrong size");

   a_qual_upper_zero: assert property ( // RULE_07
      (rd_en && addr == break_pkg::OFF_A_CYCLE_QUAL) |=> (rd_data[31:8] == 24'h00_0000))
      else $error("qualifier register upper bits read nonzero");

   a_b_exact_hit: assert property ( // RULE_08
      (pick_b.valid && pick_b.addr == q_reg.b_addr) |=> match_b)
      else $error("channel B missed an exact address match");

   a_b_unmasked_differs: assert property ( // RULE_09
      (((pick_b.addr ^ q_reg.b_addr) & ~q_reg.b_mask) != '0) |=> !match_b)
      else $error("channel B matched with an unmasked address bit differing");

   a_a_exact_hit: assert property ( // RULE_10
      (a_all_open && pick_a.valid && pick_a.addr == q_reg.a_addr) |=> match_a)
      else $error("channel A missed an exact address match");

   a_match_has_cycle: assert property ( // RULE_11
      match_a |-> $past(pick_a.valid) && $past(type_ok) && $past(dir_ok))
      else $error("channel A match without a qualifying bus cycle");

   a_irq_follows: assert property (
      $rose(q_reg.evt_status[break_pkg::EVT_A_POS]) && q_reg.evt_mask[0] |-> irq)
      else $error("interrupt not raised for an unmasked channel A event");

   ////////////////////////////////////////////////////////////////////////////////
   // register port, event and extra qualifier checks

   // zero outside the answer cycle lets read data of several slaves be or-ed
   a_rd_idle_zero: assert property (
      !rd_en |=> (rd_data == 32'h0000_0000))
      else $error("read data not zero outside a read answer cycle");

   a_evt_a_sets: assert property (
      a_hit_now |=> q_reg.evt_status[break_pkg::EVT_A_POS])
      else $error("channel A event did not set its status bit");

   a_evt_b_sets: assert property (
      b_hit_now |=> q_reg.evt_status[break_pkg::EVT_B_POS])
      else $error("channel B event did not set its status bit");

   a_evt_a_clear: assert property (
      (wr_en && addr == break_pkg::OFF_EVT_STATUS && wr_data[break_pkg::EVT_A_POS]
       && !a_hit_now) |=> !q_reg.evt_status[break_pkg::EVT_A_POS])
      else $error("channel A status bit not cleared by a write of one");

   a_evt_b_clear: assert property (
      (wr_en && addr == break_pkg::OFF_EVT_STATUS && wr_data[break_pkg::EVT_B_POS]
       && !b_hit_now) |=> !q_reg.evt_status[break_pkg::EVT_B_POS])
      else $error("channel B status bit not cleared by a write of one");

   a_irq_level: assert property (
      irq == (|(q_reg.evt_status & q_reg.evt_mask)))
      else $error("interrupt level disagrees with status and mask");

   a_data_only: assert property ( // RULE_04
      (a_type == break_pkg::TYPE_DATA && pick_a.fetch) |=> !match_a)
      else $error("channel A matched a fetch while set for data only");

   a_write_only: assert property ( // RULE_05
      (a_dir == break_pkg::DIR_WRITE && !pick_a.write) |=> !match_a)
      else $error("channel A matched a read while set for writes only");

   a_lbus_source: assert property ( // RULE_03
      (a_sel == break_pkg::SEL_L && !local_addr_bus.valid) |=> !match_a)
      else $error("channel A matched without an L bus cycle");

   a_lbus_alt: assert property ( // RULE_03
      (a_sel == break_pkg::SEL_L_ALT && !local_addr_bus.valid) |=> !match_a)
      else $error("channel A matched without an L bus cycle on code 11");

   a_masked_hit: assert property ( // RULE_02
      (a_all_open && pick_a.valid
       && (((pick_a.addr ^ q_reg.a_addr) & ~q_reg.a_mask) == '0)) |=> match_a)
      else $error("channel A missed a cycle differing only in masked bits");

   a_b_sel_off: assert property ( // RULE_08
      (q_reg.b_sel == break_pkg::SEL_OFF) |=> !match_b)
      else $error("channel B matched with bus select disabled");

   a_b_ibus_source: assert property ( // RULE_08
      (q_reg.b_sel == break_pkg::SEL_I && !internal_addr_bus.valid) |=> !match_b)
      else $error("channel B matched without an I bus cycle");

   a_b_full_mask: assert property ( // RULE_09
      (pick_b.valid && q_reg.b_mask == 32'hFFFF_FFFF) |=> match_b)
      else $error("channel B missed a cycle with all address bits masked");

   a_b_has_cycle: assert property ( // RULE_08
      match_b |-> $past(pick_b.valid) && $past(b_addr_hit))
      else $error("channel B match without a matching bus cycle");

   c_match_a: cover property (match_a);
   c_match_b: cover property (match_b);
   c_both_match: cover property (match_a && match_b);
   c_irq_raise: cover property ($rose(irq));
   c_a_on_ibus: cover property (a_sel == break_pkg::SEL_I && a_hit_now);

endmodule

// file: break_pkg.sv
// Purpose: shared constants and types of the break-condition compare block
// Assumes: 32-bit processor addresses, byte-addressed register port
// Notes: all offsets, field positions and reset values live here
package break_pkg;

   // register byte offsets
   localparam logic [7:0] OFF_A_MATCH_ADDR = 8'h00;
   localparam logic [7:0] OFF_A_ADDR_MASK = 8'h04;
   localparam logic [7:0] OFF_A_CYCLE_QUAL = 8'h08;
   localparam logic [7:0] OFF_B_MATCH_ADDR = 8'h0C;
   localparam logic [7:0] OFF_B_ADDR_MASK = 8'h10;
   localparam logic [7:0] OFF_B_BUS_SEL = 8'h14;
   localparam logic [7:0] OFF_EVT_STATUS = 8'h18;
   localparam logic [7:0] OFF_EVT_MASK = 8'h1C;

   // reset values
   localparam logic [31:0] RST_ADDR = 32'h0000_0000;
   localparam logic [31:0] RST_MASK = 32'h0000_0000;
   localparam logic [7:0] RST_QUAL = 8'h00;
   localparam logic [1:0] RST_SEL = 2'h0;
   localparam logic [1:0] RST_EVT = 2'h0;

   // cycle qualifier field positions (each field two bits wide)
   localparam int QUAL_BUS_SEL_POS = 6;
   localparam int QUAL_TYPE_POS = 4;
   localparam int QUAL_DIR_POS = 2;
   localparam int QUAL_SIZE_POS = 0;

   // field codes
   localparam logic [1:0] SEL_OFF = 2'h0;
   localparam logic [1:0] SEL_L = 2'h1;
   localparam logic [1:0] SEL_I = 2'h2;
   localparam logic [1:0] SEL_L_ALT = 2'h3;
   localparam logic [1:0] TYPE_FETCH = 2'h1;
   localparam logic [1:0] TYPE_DATA = 2'h2;
   localparam logic [1:0] TYPE_BOTH = 2'h3;
   localparam logic [1:0] DIR_READ = 2'h1;
   localparam logic [1:0] DIR_WRITE = 2'h2;
   localparam logic [1:0] DIR_BOTH = 2'h3;
   localparam logic [1:0] SIZE_ANY = 2'h0;
   localparam logic [1:0] SIZE_BYTE = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] SIZE_LONG = 2'h3;

   // event status bit positions
   localparam int EVT_A_POS = 0;
   localparam int EVT_B_POS = 1;

   // one processor bus cycle as seen on either internal bus
   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic fetch;
      logic write;
      logic [1:0] size;
   } bus_cycle_t;

endpackage

// file: addr_match.sv
// Purpose: masked address comparator for one break channel
// Assumes: mask bit set means the address bit is ignored
// Notes: purely combinational
`timescale 1ns/1ps
module addr_match #(
   parameter int WIDTH = 32
) (
   input wire logic [WIDTH-1:0] addr,
   input wire logic [WIDTH-1:0] ref_addr,
   input wire logic [WIDTH-1:0] mask,
   output logic hit
);
   // a set mask bit removes that position from the compare
   always_comb begin
      hit = (((addr ^ ref_addr) & ~mask) == '0); // RULE_01
   end
endmodule

// file: bus_pick.sv
// Purpose: choose the L or I bus cycle for one break channel
// Assumes: both buses are on the processor clock
// Notes: select code 00 yields an invalid cycle, so no compare takes place
`timescale 1ns/1ps
module bus_pick (
   input wire logic [1:0] sel,
   input wire break_pkg::bus_cycle_t l_cycle,
   input wire break_pkg::bus_cycle_t i_cycle,
   output break_pkg::bus_cycle_t picked
);
   always_comb begin
      picked = l_cycle;
      unique case (sel)
         break_pkg::SEL_OFF: begin
            picked.valid = 1'b0; // RULE_03
         end
         break_pkg::SEL_L: begin
            picked = l_cycle;
         end
         break_pkg::SEL_I: begin
            picked = i_cycle;
         end
         break_pkg::SEL_L_ALT: begin
            picked = l_cycle; // RULE_03
         end
      endcase
   end
endmodule

// file: cpu_bus_model.sv
// Purpose: processor side of the L and I buses, one bus cycle per call
// Assumes: cycles are launched just after a rising clock edge
// Notes: a released bus keeps valid low and shows inverted leftovers
`timescale 1ns/1ps
module cpu_bus_model (
   input wire logic clk,
   output break_pkg::bus_cycle_t l_bus,
   output break_pkg::bus_cycle_t i_bus
);
   initial begin
      l_bus = '0;
      i_bus = '0;
   end

   task automatic drive(input break_pkg::bus_cycle_t l, input break_pkg::bus_cycle_t i);
      @(posedge clk);
      l_bus <= l;
      i_bus <= i;
      @(posedge clk);
      // inverted leftovers so a stale cycle can never look like a fresh match
      l_bus <= {1'b0, ~l[35:0]};
      i_bus <= {1'b0, ~i[35:0]};
   endtask
endmodule

// file: tb_break_compare.sv
// Purpose: self-checking bench of the break-condition compare block
// Assumes: fixed one-cycle register and match latency
// Notes: every scenario is a task that drives and judges on its own
`timescale 1ns/1ps
module tb_break_compare;
   logic clk;
   logic reset;
   logic [7:0] addr;
   logic [31:0] wr_data;
   logic wr_en;
   logic rd_en;
   logic [31:0] rd_data;
   break_pkg::bus_cycle_t l_bus;
   break_pkg::bus_cycle_t i_bus;
   logic match_a;
   logic match_b;
   logic irq;
   int n_fail;
   int compares;

   break_compare dut_u (.clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .local_addr_bus(l_bus),
      .internal_addr_bus(i_bus), .match_a(match_a), .match_b(match_b), .irq(irq));
   cpu_bus_model u_bus (.clk(clk), .l_bus(l_bus), .i_bus(i_bus));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (n_fail == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      chk(rd_data, e);
   endtask

   // one cycle on the chosen bus, the other bus idle, then both match outputs judged
   task automatic cyc(input logic on_i, input logic [31:0] a, input logic f, input logic w,
         input logic [1:0] s, input logic ea, input logic eb);
      break_pkg::bus_cycle_t c;
      break_pkg::bus_cycle_t idle;
      c = '{valid: 1'b1, addr: a, fetch: f, write: w, size: s};
      idle = '{valid: 1'b0, addr: a, fetch: f, write: w, size: s};
      if (on_i) begin
         u_bus.drive(idle, c);
      end else begin
         u_bus.drive(c, idle);
      end
      #1;
      chk({31'h0000_0000, match_a}, {31'h0000_0000, ea});
      chk({31'h0000_0000, match_b}, {31'h0000_0000, eb});
   endtask

   function automatic logic exp_a(input logic [7:0] q, input logic on_i, input logic f,
         input logic w, input logic [1:0] s);
      logic bus_ok;
      bus_ok = on_i ? (q[7:6] == 2'h2) : (q[7:6] == 2'h1 || q[7:6] == 2'h3);
      return bus_ok && (f ? q[4] : q[5]) && (w ? q[3] : q[2])
         && (q[1:0] == 2'h0 || q[1:0] == s);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   task automatic sc_reset();
      for (int k = 0; k < 9; k++) begin
         rd(8'(k * 4), 32'h0000_0000);
      end
   endtask

   task automatic sc_regs();
      wr(break_pkg::OFF_A_MATCH_ADDR, 32'hA5C3_0F96);
      rd(break_pkg::OFF_A_MATCH_ADDR, 32'hA5C3_0F96);
      wr(break_pkg::OFF_A_ADDR_MASK, 32'h8000_0001);
      rd(break_pkg::OFF_A_ADDR_MASK, 32'h8000_0001);
      wr(break_pkg::OFF_B_MATCH_ADDR, 32'h5A3C_F069);
      rd(break_pkg::OFF_B_MATCH_ADDR, 32'h5A3C_F069);
      wr(break_pkg::OFF_B_ADDR_MASK, 32'h0001_8000);
      rd(break_pkg::OFF_B_ADDR_MASK, 32'h0001_8000);
      // software keeps the reserved upper byte zero
      wr(break_pkg::OFF_A_CYCLE_QUAL, 32'h0000_00FF);
      rd(break_pkg::OFF_A_CYCLE_QUAL, 32'h0000_00FF);
      wr(break_pkg::OFF_B_BUS_SEL, 32'h0000_0000);
   endtask

   task automatic sc_mask_a();
      wr(break_pkg::OFF_A_MATCH_ADDR, 32'h1234_5678);
      wr(break_pkg::OFF_A_ADDR_MASK, 32'h0000_0FFF);
      wr(break_pkg::OFF_A_CYCLE_QUAL, 32'h0000_007C);
      for (int b = 0; b < 32; b++) begin
         cyc(1'b0, 32'h1234_5678 ^ (32'h1 << b), 1'b1, 1'b0, 2'h3, b < 12, 1'b0);
      end
      wr(break_pkg::OFF_A_ADDR_MASK, 32'hFFFF_FFFF);
      cyc(1'b0, 32'hEDCB_A987, 1'b0, 1'b1, 2'h1, 1'b1, 1'b0);
      wr(break_pkg::OFF_A_ADDR_MASK, 32'h0000_0000);
   endtask

   task automatic sc_qual();
      logic [1:0] s;
      for (int q = 0; q < 256; q++) begin
         wr(break_pkg::OFF_A_CYCLE_QUAL, 32'(q));
         for (int v = 0; v < 16; v++) begin
            s = v[3] ? q[1:0] : q[1:0] + 2'h1;
            // bus cycles never carry size code 00
            if (s == 2'h0) begin
               s = 2'h2;
            end
            cyc(v[0], 32'h1234_5678, v[1], v[2], s, exp_a(8'(q), v[0], v[1], v[2], s),
               1'b0);
         end
      end
      wr(break_pkg::OFF_A_CYCLE_QUAL, 32'h0000_0000);
   endtask

   task automatic sc_chan_b();
      wr(break_pkg::OFF_B_MATCH_ADDR, 32'h89AB_CDEF);
      wr(break_pkg::OFF_B_ADDR_MASK, 32'hF000_0000);
      for (int sel = 0; sel < 4; sel++) begin
         wr(break_pkg::OFF_B_BUS_SEL, 32'(sel));
         cyc(1'b0, 32'h79AB_CDEF, 1'b0, 1'b0, 2'h2, 1'b0, sel == 1 || sel == 3);
         cyc(1'b1, 32'h19AB_CDEF, 1'b1, 1'b1, 2'h1, 1'b0, sel == 2);
         cyc(1'b1, 32'h89AB_CDEE, 1'b1, 1'b1, 2'h1, 1'b0, 1'b0);
      end
   endtask

   task automatic sc_irq();
      wr(break_pkg::OFF_EVT_STATUS, 32'h0000_0003);
      rd(break_pkg::OFF_EVT_STATUS, 32'h0000_0000);
      cyc(1'b0, 32'h89AB_CDEF, 1'b0, 1'b0, 2'h2, 1'b0, 1'b1);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      rd(break_pkg::OFF_EVT_STATUS, 32'h0000_0002);
      wr(break_pkg::OFF_EVT_MASK, 32'h0000_0002);
      rd(break_pkg::OFF_EVT_MASK, 32'h0000_0002);
      chk({31'h0000_0000, irq}, 32'h0000_0001);
      wr(break_pkg::OFF_EVT_STATUS, 32'h0000_0002);
      rd(break_pkg::OFF_EVT_STATUS, 32'h0000_0000);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      wr(break_pkg::OFF_EVT_MASK, 32'h0000_0001);
      wr(break_pkg::OFF_A_CYCLE_QUAL, 32'h0000_00BF);
      cyc(1'b1, 32'h1234_5678, 1'b0, 1'b1, 2'h3, 1'b1, 1'b0);
      chk({31'h0000_0000, irq}, 32'h0000_0001);
   endtask

   // reset in mid-run must bring every register and output back to zero
   task automatic sc_reset_again();
      wr(break_pkg::OFF_A_MATCH_ADDR, 32'hFFFF_0000);
      wr(break_pkg::OFF_EVT_MASK, 32'h0000_0003);
      @(posedge clk);
      reset <= 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      #1;
      chk({29'h0000_0000, match_a, match_b, irq}, 32'h0000_0000);
      sc_reset();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      n_fail = 0;
      compares = 0;
      reset = 1'b1;
      addr = 8'h00;
      wr_data = 32'h0000_0000;
      wr_en = 1'b0;
      rd_en = 1'b0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      #1;
      chk({29'h0000_0000, match_a, match_b, irq}, 32'h0000_0000);
      sc_reset();
      sc_regs();
      sc_mask_a();
      sc_qual();
      sc_chan_b();
      sc_irq();
      sc_reset_again();
      report_and_stop();
   end

   // cuts a hang short; the full sequence needs well under a quarter of this
   initial begin
      #1_000_000;
      n_fail++;
      report_and_stop();
   end
endmodule
